// ---- common/mfs_pkg.sv ----
// Shared constants and types of the field-sensor two-wire target
package mfs_pkg;

   // Register offsets
   localparam logic [7:0] REG_X_LO = 8'h00;
   localparam logic [7:0] REG_X_HI = 8'h01;
   localparam logic [7:0] REG_Y_LO = 8'h02;
   localparam logic [7:0] REG_Y_HI = 8'h03;
   localparam logic [7:0] REG_Z_LO = 8'h04;
   localparam logic [7:0] REG_Z_HI = 8'h05;
   localparam logic [7:0] REG_STATUS = 8'h06;
   localparam logic [7:0] REG_CTRL0 = 8'h07;
   localparam logic [7:0] REG_CTRL1 = 8'h08;
   localparam logic [7:0] REG_PART_ID = 8'h20;

   // Field positions and reset values
   localparam int STAT_DONE_BIT = 0;
   localparam int TAKE_MEAS_BIT = 0;
   localparam int RES_SEL_LO = 0;
   localparam logic [1:0] RES_SEL_RESET = 2'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Fixed upper part of the seven-bit target address
   localparam logic [3:0] ADDR_FIXED = 4'h6;

   // Bit slot counts within one byte frame
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   // Acquisition times for all three channels, per resolution setting
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_MEAS_BW00_NS = 7920000;
   localparam int T_MEAS_BW01_NS = 4080000;
   localparam int T_MEAS_BW10_NS = 2160000;
   localparam int T_MEAS_BW11_NS = 1200000;
   localparam int MEAS_CYC_BW00 = T_MEAS_BW00_NS / CLK_PERIOD_NS;
   localparam int MEAS_CYC_BW01 = T_MEAS_BW01_NS / CLK_PERIOD_NS;
   localparam int MEAS_CYC_BW10 = T_MEAS_BW10_NS / CLK_PERIOD_NS;
   localparam int MEAS_CYC_BW11 = T_MEAS_BW11_NS / CLK_PERIOD_NS;
   localparam int NUM_CHANNELS = 3;
   localparam int CNT_W = 20;

   localparam int FIFO_DEPTH = 16;

   typedef logic [CNT_W-1:0] mfs_cnt_t;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } mfs_field_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } mfs_wr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_REG = 3'b011,
      ST_WDATA = 3'b010,
      ST_RDATA = 3'b110
   } mfs_bus_st_t;

   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_X = 2'b01,
      M_Y = 2'b11,
      M_Z = 2'b10
   } mfs_meas_st_t;

endpackage

// ---- core/mfs_fifo.sv ----
// Register-write FIFO between the bus engine and the register file
`timescale 1ns/1ps
module mfs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import mfs_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_FILL = (AW+1)'(DEPTH);
   localparam logic [AW:0] PTR_ONE = (AW+1)'(1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic [AW:0] fill;

   // Extra pointer bit tells full from empty without a counter
   assign fill = wp_r - rp_r;
   assign in_ready = (fill != FULL_FILL);
   assign out_valid = (fill != '0);
   assign out_data = mem[rp_r[AW-1:0]];

   // Storage
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wp_r <= wp_r + PTR_ONE;
         end
         if (out_valid && out_ready) begin
            rp_r <= rp_r + PTR_ONE;
         end
      end
   end

endmodule // mfs_fifo

// ---- core/mfs_meas.sv ----
// Acquisition timebase: three channels in turn, then automatic power-down
`timescale 1ns/1ps
module mfs_meas #(
   parameter int CYC00 = mfs_pkg::MEAS_CYC_BW00,
   parameter int CYC01 = mfs_pkg::MEAS_CYC_BW01,
   parameter int CYC10 = mfs_pkg::MEAS_CYC_BW10,
   parameter int CYC11 = mfs_pkg::MEAS_CYC_BW11
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [1:0] res_sel,
   input wire mfs_pkg::mfs_field_t field,
   output logic busy,
   output logic done,
   output mfs_pkg::mfs_field_t result
);
   import mfs_pkg::*;

   // Each channel takes a third of the whole acquisition time
   localparam mfs_cnt_t PH00 = mfs_cnt_t'(CYC00 / NUM_CHANNELS);
   localparam mfs_cnt_t PH01 = mfs_cnt_t'(CYC01 / NUM_CHANNELS);
   localparam mfs_cnt_t PH10 = mfs_cnt_t'(CYC10 / NUM_CHANNELS);
   localparam mfs_cnt_t PH11 = mfs_cnt_t'(CYC11 / NUM_CHANNELS);

   mfs_meas_st_t st_r;
   mfs_cnt_t cnt_r;
   mfs_cnt_t phase_len_r;
   logic phase_end;

   assign phase_end = (st_r != M_IDLE) && (cnt_r == mfs_cnt_t'(1));
   assign busy = (st_r != M_IDLE);

   // Sequencer; a trigger while busy is dropped so results stay coherent
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= M_IDLE;
         cnt_r <= '0;
         phase_len_r <= PH00;
         done <= 1'b0;
         result <= '0;
      end else begin
         done <= 1'b0;
         if (st_r == M_IDLE) begin
            if (start) begin
               unique case (res_sel)
                  2'h0: phase_len_r <= PH00;
                  2'h1: phase_len_r <= PH01;
                  2'h2: phase_len_r <= PH10;
                  2'h3: phase_len_r <= PH11;
               endcase
               unique case (res_sel)
                  2'h0: cnt_r <= PH00;
                  2'h1: cnt_r <= PH01;
                  2'h2: cnt_r <= PH10;
                  2'h3: cnt_r <= PH11;
               endcase
               st_r <= M_X;
            end
         end else if (phase_end) begin
            cnt_r <= phase_len_r;
            unique case (st_r)
               M_X: begin
                  result.x <= field.x;
                  st_r <= M_Y;
               end
               M_Y: begin
                  result.y <= field.y;
                  st_r <= M_Z;
               end
               M_Z: begin
                  result.z <= field.z;
                  done <= 1'b1;
                  st_r <= M_IDLE;
               end
               default: st_r <= M_IDLE;
            endcase
         end else begin
            cnt_r <= cnt_r - mfs_cnt_t'(1);
         end
      end
   end

   a_channel_order: assert property (@(posedge clk) disable iff (rst)
      (phase_end && st_r == M_X) |=> (st_r == M_Y) ##0 (cnt_r == phase_len_r))
      else $error("channel sequence broken after X");

   a_auto_power_down: assert property (@(posedge clk) disable iff (rst)
      (phase_end && st_r == M_Z) |=> (done && !busy) ##1 !done)
      else $error("no power-down after acquisition");

endmodule // mfs_meas

// ---- core/mfs_sensor_target.sv ----
// Two-wire target of the field sensor: bus engine, registers, acquisition
`timescale 1ns/1ps

module mfs_sensor_target #(
   parameter int MEAS_CYC_BW00 = mfs_pkg::MEAS_CYC_BW00,
   parameter int MEAS_CYC_BW01 = mfs_pkg::MEAS_CYC_BW01,
   parameter int MEAS_CYC_BW10 = mfs_pkg::MEAS_CYC_BW10,
   parameter int MEAS_CYC_BW11 = mfs_pkg::MEAS_CYC_BW11,
   parameter logic [2:0] ADDR_LOW = 3'h0,
   // Value is arbitrary
   parameter logic [7:0] PART_ID_VALUE = 8'h5a
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic SCL_CLK,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire mfs_pkg::mfs_field_t FIELD,
   output logic POWER_DOWN,
   output logic MEAS_DONE
);
   import mfs_pkg::*;

   // Link domain: bit capture on the controller's clock
   logic link_bit_r = 1'b0;
   logic link_tog_r = 1'b0;

   // System domain: synchronisers and edge history
   logic tog_s1_r;
   logic tog_s2_r;
   logic tog_s3_r;
   logic scl_s1_r;
   logic scl_s2_r;
   logic scl_s3_r;
   logic sda_s1_r;
   logic sda_s2_r;
   logic sda_s3_r;
   logic bit_ev;
   logic start_det;
   logic stop_det;
   logic scl_fall;

   // Bus engine
   mfs_bus_st_t st_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] rx_byte;
   logic [7:0] ptr_r;
   logic [7:0] tx_r;
   logic ack_r;
   logic rw_r;
   logic byte_done;
   logic ack_slot_ev;
   logic addr_match;
   logic sda_oe_r;
   logic sda_o_r;

   // Register file and acquisition
   logic [1:0] res_sel_r;
   logic trig_r;
   logic done_r;
   logic pd_r;
   logic meas_busy;
   logic meas_done;
   mfs_field_t result;

   // Write path
   mfs_wr_t wr_in;
   mfs_wr_t wr_out;
   logic wr_push;
   logic wr_ready;
   logic wr_valid;
   logic wr_take;

   // Read multiplexer; write-only control bits read back as zero
   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      logic [7:0] v;
      v = BYTE_RESET;
      unique case (a)
         REG_X_LO: v = result.x[7:0];
         REG_X_HI: v = result.x[15:8];
         REG_Y_LO: v = result.y[7:0];
         REG_Y_HI: v = result.y[15:8];
         REG_Z_LO: v = result.z[7:0];
         REG_Z_HI: v = result.z[15:8];
         REG_STATUS: v[STAT_DONE_BIT] = done_r;
         REG_CTRL1: v[RES_SEL_LO +: 2] = res_sel_r;
         REG_PART_ID: v = PART_ID_VALUE;
         default: v = BYTE_RESET;
      endcase
      return v;
   endfunction

   // Sample data on the rising clock edge; the toggle announces a new bit.
   // Link clock may stop between frames, so no reset here.
   always_ff @(posedge SCL_CLK) begin
      link_bit_r <= SDA_I;
      link_tog_r <= ~link_tog_r;
   end

   // Bit announcement crosses by toggle; the bit itself is stable until next rise
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_s3_r <= 1'b0;
      end else begin
         tog_s1_r <= link_tog_r;
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
      end
   end

   // Line levels for start, stop and drive timing; idle bus is high
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_s3_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_s3_r <= 1'b1;
      end else begin
         scl_s1_r <= SCL_CLK;
         scl_s2_r <= scl_s1_r;
         scl_s3_r <= scl_s2_r;
         sda_s1_r <= SDA_I;
         sda_s2_r <= sda_s1_r;
         sda_s3_r <= sda_s2_r;
      end
   end

   // Edge decode on second and third stages only
   assign bit_ev = tog_s2_r ^ tog_s3_r;
   assign start_det = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
   assign stop_det = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
   assign scl_fall = scl_s3_r && !scl_s2_r;

   // Frame position decode
   assign rx_byte = {sh_r[6:0], link_bit_r};
   assign byte_done = bit_ev && !start_det && !stop_det && (st_r != ST_IDLE)
      && (cnt_r == LAST_BIT);
   assign ack_slot_ev = bit_ev && !start_det && !stop_det && (st_r != ST_IDLE)
      && (cnt_r == ACK_SLOT);
   assign addr_match = (rx_byte[7:1] == {ADDR_FIXED, ADDR_LOW});

   // Data bytes go to the FIFO with the pointer they belong to
   assign wr_push = byte_done && (st_r == ST_WDATA);
   assign wr_in = '{addr: ptr_r, data: rx_byte};

   // Bus engine: frame counting, address check, pointer and turnaround
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_r <= ST_IDLE;
         cnt_r <= '0;
         sh_r <= BYTE_RESET;
         ack_r <= 1'b0;
         rw_r <= 1'b0;
         ptr_r <= BYTE_RESET;
         tx_r <= BYTE_RESET;
      end else if (start_det) begin
         st_r <= ST_ADDR;
         cnt_r <= '0;
         ack_r <= 1'b0;
      end else if (stop_det) begin
         st_r <= ST_IDLE;
         cnt_r <= '0;
         ack_r <= 1'b0;
      end else if (bit_ev && st_r != ST_IDLE) begin
         if (cnt_r != ACK_SLOT) begin
            sh_r <= rx_byte;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == LAST_BIT) begin
               unique case (st_r)
                  ST_ADDR: begin
                     ack_r <= addr_match;
                     rw_r <= rx_byte[0];
                     if (!addr_match) begin
                        st_r <= ST_IDLE;
                     end
                  end
                  ST_REG: begin
                     ptr_r <= rx_byte;
                     ack_r <= 1'b1;
                  end
                  ST_WDATA: begin
                     // A full write queue refuses the byte instead of losing it
                     ack_r <= wr_ready;
                     if (wr_ready) begin
                        ptr_r <= ptr_r + 8'h01;
                     end
                  end
                  ST_RDATA: ack_r <= 1'b0;
                  default: st_r <= ST_IDLE;
               endcase
            end
         end else begin
            cnt_r <= '0;
            unique case (st_r)
               ST_ADDR: begin
                  if (rw_r) begin
                     st_r <= ST_RDATA;
                     tx_r <= rd_byte(ptr_r);
                  end else begin
                     st_r <= ST_REG;
                  end
               end
               ST_REG: st_r <= ST_WDATA;
               ST_WDATA: st_r <= ST_WDATA;
               ST_RDATA: begin
                  if (!link_bit_r) begin
                     ptr_r <= ptr_r + 8'h01;
                     tx_r <= rd_byte(ptr_r + 8'h01);
                  end else begin
                     st_r <= ST_IDLE;
                  end
               end
               default: st_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Data line changes only while the clock is low, so it never fakes a start
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sda_oe_r <= 1'b0;
         sda_o_r <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe_r <= 1'b0;
      end else if (scl_fall) begin
         if (st_r == ST_RDATA && cnt_r != ACK_SLOT) begin
            sda_oe_r <= ~tx_r[~cnt_r[2:0]];
         end else if (cnt_r == ACK_SLOT && ack_r && st_r != ST_RDATA) begin
            sda_oe_r <= 1'b1;
         end else begin
            sda_oe_r <= 1'b0;
         end
      end
   end

   mfs_fifo #(
      .WIDTH($bits(mfs_wr_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(CLK_SYS),
      .rst(RST),
      .in_valid(wr_push),
      .in_ready(wr_ready),
      .in_data(wr_in),
      .out_valid(wr_valid),
      .out_ready(!meas_done),
      .out_data(wr_out)
   );

   // Drain pauses on the closing cycle of an acquisition; a trigger taken the cycle
   // before still meets the status update of the old one, where completion wins
   assign wr_take = wr_valid && !meas_done;

   // Register writes; the trigger bit is a one-cycle pulse, not stored
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         res_sel_r <= RES_SEL_RESET;
         trig_r <= 1'b0;
      end else begin
         trig_r <= wr_take && (wr_out.addr == REG_CTRL0)
            && wr_out.data[TAKE_MEAS_BIT];
         if (wr_take && wr_out.addr == REG_CTRL1) begin
            res_sel_r <= wr_out.data[RES_SEL_LO +: 2];
         end
      end
   end

   mfs_meas #(
      .CYC00(MEAS_CYC_BW00),
      .CYC01(MEAS_CYC_BW01),
      .CYC10(MEAS_CYC_BW10),
      .CYC11(MEAS_CYC_BW11)
   ) u_meas (
      .clk(CLK_SYS),
      .rst(RST),
      .start(trig_r),
      .res_sel(res_sel_r),
      .field(FIELD),
      .busy(meas_busy),
      .done(meas_done),
      .result(result)
   );

   // Completion flag: a new acquisition clears it, completion wins over that
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         done_r <= 1'b0;
      end else if (meas_done) begin
         done_r <= 1'b1;
      end else if (trig_r && !meas_busy) begin
         done_r <= 1'b0;
      end
   end

   // Power state follows the sequencer one cycle late
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pd_r <= 1'b1;
      end else begin
         pd_r <= !meas_busy;
      end
   end

   assign SDA_O = sda_o_r;
   assign SDA_OE = sda_oe_r;
   assign POWER_DOWN = pd_r;
   assign MEAS_DONE = done_r;

   a_start_enters_addr: assert property (@(posedge CLK_SYS) disable iff (RST)
      start_det |=> (st_r == ST_ADDR) && (cnt_r == 4'h0) && !sda_oe_r)
      else $error("start did not open address phase");

   a_stop_ends_xfer: assert property (@(posedge CLK_SYS) disable iff (RST)
      stop_det |=> (st_r == ST_IDLE) && !sda_oe_r)
      else $error("stop did not end transfer");

   a_ack_on_match: assert property (@(posedge CLK_SYS) disable iff (RST)
      (byte_done && st_r == ST_ADDR && addr_match)
      |=> ack_r && (cnt_r == ACK_SLOT) && (st_r == ST_ADDR))
      else $error("matching address not acknowledged");

   a_nomatch_silent: assert property (@(posedge CLK_SYS) disable iff (RST)
      (byte_done && st_r == ST_ADDR && !addr_match)
      |=> (st_r == ST_IDLE) && !ack_r ##1 !sda_oe_r)
      else $error("foreign address disturbed the bus");

   a_read_turnaround: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ack_slot_ev && st_r == ST_ADDR && rw_r)
      |=> (st_r == ST_RDATA) && (tx_r == rd_byte(ptr_r)))
      else $error("read direction did not load register");

   a_ptr_advance: assert property (@(posedge CLK_SYS) disable iff (RST)
      (wr_push && wr_ready) |=> (ptr_r == $past(ptr_r) + 8'h01))
      else $error("pointer did not advance after write");

   a_burst_order: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ack_slot_ev && st_r == ST_RDATA && !link_bit_r)
      |=> (ptr_r == $past(ptr_r) + 8'h01) && (st_r == ST_RDATA))
      else $error("read burst did not step");

   a_msb_first: assert property (@(posedge CLK_SYS) disable iff (RST)
      (scl_fall && !start_det && !stop_det && st_r == ST_RDATA && cnt_r == 4'h0)
      |=> (sda_oe_r == !tx_r[7]))
      else $error("first read bit is not the top bit");

   a_trigger_starts: assert property (@(posedge CLK_SYS) disable iff (RST)
      (trig_r && !meas_busy) |=> meas_busy && !done_r ##1 !pd_r)
      else $error("trigger did not start acquisition");

   a_done_sets_status: assert property (@(posedge CLK_SYS) disable iff (RST)
      meas_done |=> done_r && (rd_byte(REG_STATUS) == (8'h01 << STAT_DONE_BIT)))
      else $error("status bit not set after acquisition");

endmodule // mfs_sensor_target

// ---- tb/mfs_bus_ctrl.sv ----
// Behavioural two-wire bus controller facing the sensor target
`timescale 1ns/1ps
module mfs_bus_ctrl #(
   parameter int Q_NS = 67
) (
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   // Both lines idle high through the pull-ups; the clock stands still outside frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Start or repeated start; odd quarter keeps the bus unrelated in phase to CLK_SYS
   task automatic bstart();
      sda_drv = 1'b1;
      #(Q_NS);
      scl = 1'b1;
      #(Q_NS);
      sda_drv = 1'b0;
      #(Q_NS);
      scl = 1'b0;
      #(Q_NS);
   endtask
   task automatic bstop();
      sda_drv = 1'b0;
      #(Q_NS);
      scl = 1'b1;
      #(Q_NS);
      sda_drv = 1'b1;
      #(Q_NS);
   endtask
   // Data moves only mid-low, far from either clock edge
   task automatic bit_slot(input logic b, output logic s);
      sda_drv = b;
      #(Q_NS);
      scl = 1'b1;
      #(Q_NS);
      s = sda_line;
      #(Q_NS);
      scl = 1'b0;
      #(Q_NS);
   endtask
   // Eight bits out, then the ninth slot samples the acknowledge
   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(d[i], s);
      end
      bit_slot(1'b1, s);
      ack = ~s;
   endtask
   // Eight bits in; acknowledge withheld on the last byte
   task automatic get(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, d[i]);
      end
      bit_slot(~ack, s);
   endtask
endmodule // mfs_bus_ctrl

// ---- tb/testbench.sv ----
// Self-checking bench of the field-sensor two-wire target
`timescale 1ns/1ps
module testbench;
   import mfs_pkg::*;
   localparam logic [2:0] LOW_BITS = 3'h5;
   localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary value
   localparam int CYC [4] = '{30, 60, 90, 120};
   localparam logic [6:0] BAD [3] = '{7'h34, 7'h75, 7'h2d};
   logic clk_sys, rst, scl, sda_drv, sda_o, sda_oe, power_down, meas_done, ack;
   logic sda_line;
   mfs_field_t field;
   logic [63:0] f;
   logic [7:0] rd [6];
   logic [31:0] rng = 32'h13;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int t_go = 0;
   int t_end = 0;
   logic pd_q = 1'b1;
   logic md_q = 1'b0;

   // Open drain: any party pulling low wins
   assign sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);

   mfs_bus_ctrl bus_u (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

   mfs_sensor_target #(
      .MEAS_CYC_BW00(CYC[0]), .MEAS_CYC_BW01(CYC[1]),
      .MEAS_CYC_BW10(CYC[2]), .MEAS_CYC_BW11(CYC[3]),
      .ADDR_LOW(LOW_BITS), .PART_ID_VALUE(ID_VAL)
   ) dut_u (
      .CLK_SYS(clk_sys), .RST(rst), .SCL_CLK(scl), .SDA_I(sda_line), .SDA_O(sda_o),
      .SDA_OE(sda_oe), .FIELD(field), .POWER_DOWN(power_down), .MEAS_DONE(meas_done)
   );

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Edge stamps of power-down and done give the acquisition length
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      pd_q <= power_down;
      md_q <= meas_done;
      if (pd_q && !power_down) t_go <= cyc;
      if (!md_q && meas_done) t_end <= cyc;
   end

   function automatic logic [31:0] next_rand();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // Burst order: low byte before high byte, X then Y then Z
   function automatic logic [7:0] exp_byte(input mfs_field_t v, input int k);
      logic [15:0] w;
      w = (k < 2) ? v.x : (k < 4) ? v.y : v.z;
      return k[0] ? w[15:8] : w[7:0];
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic open_reg(input logic [7:0] r);
      bus_u.bstart();
      bus_u.put({ADDR_FIXED, LOW_BITS, 1'b0}, ack);
      check(16'(ack), 16'h1);
      bus_u.put(r, ack);
      check(16'(ack), 16'h1);
   endtask

   task automatic wr_reg(input logic [7:0] r, input logic [7:0] d);
      open_reg(r);
      bus_u.put(d, ack);
      check(16'(ack), 16'h1);
      bus_u.bstop();
   endtask

   task automatic rd_regs(input logic [7:0] r, input int n);
      open_reg(r);
      bus_u.bstart();
      bus_u.put({ADDR_FIXED, LOW_BITS, 1'b1}, ack);
      check(16'(ack), 16'h1);
      for (int i = 0; i < n; i++) begin
         bus_u.get(i < n - 1, rd[i]);
      end
      bus_u.bstop();
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hung handshake ends the run through the same verdict
   initial begin
      #500000;
      fail_count++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      field = '0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check(16'(power_down), 16'h1);
      check(16'(meas_done), 16'h0);
      // Foreign addresses get no acknowledge and the line stays released
      foreach (BAD[k]) begin
         bus_u.bstart();
         bus_u.put({BAD[k], 1'b0}, ack);
         check(16'(ack), 16'h0);
         bus_u.bstop();
      end
      wr_reg(REG_PART_ID, 8'hff);
      rd_regs(REG_PART_ID, 1);
      check(16'(rd[0]), 16'(ID_VAL));
      rd_regs(8'h30, 1);
      check(16'(rd[0]), 16'h0);
      for (int m = 0; m < 4; m++) begin
         f = {next_rand(), next_rand()};
         @(posedge clk_sys);
         field <= f[47:0];
         // Burst: harmless control-zero byte, then the pointer steps to control one
         open_reg(REG_CTRL0);
         bus_u.put(8'h00, ack);
         bus_u.put({6'h0, 2'(m)}, ack);
         bus_u.bstop();
         rd_regs(REG_CTRL1, 1);
         check(16'(rd[0]), 16'(m));
         wr_reg(REG_CTRL0, 8'h01);
         for (int p = 0; p < 20; p++) begin
            rd_regs(REG_STATUS, 1);
            if (rd[0][STAT_DONE_BIT] === 1'b1) break;
         end
         check(16'(rd[0][STAT_DONE_BIT]), 16'h1);
         check(16'(t_end - t_go >= CYC[m] - 3 && t_end - t_go <= CYC[m] + 1), 16'h1);
         check(16'(power_down), 16'h1);
         check(16'(meas_done), 16'h1);
         rd_regs(REG_X_LO, 6);
         for (int k = 0; k < 6; k++) begin
            check(16'(rd[k]), 16'(exp_byte(f[47:0], k)));
         end
      end
      // Reset in mid-run: the done flag set above must fall, the X result returns to zero
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check(16'(power_down), 16'h1);
      check(16'(meas_done), 16'h0);
      rd_regs(REG_X_LO, 2);
      check(16'(rd[0]), 16'h0);
      check(16'(rd[1]), 16'h0);
      print_verdict();
   end
endmodule // testbench
